// ===== rtl/ocd_chan_div.sv
// one channel divider with duty correction and boundary-aligned run control
module ocd_chan_div
  import ocd_pkg::*;
#(
  parameter int DIV_W = RATIO_W
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic hold_i,
  input wire logic [DIV_W-1:0] ratio_m1_i,
  input wire logic run_req_i,
  output logic wave_o,
  output logic running_o
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] n_m1;
    logic run;
    logic hi;
    logic ext;
  } ocd_div_state_s;

  ocd_div_state_s st;
  ocd_div_state_s next_st;

  always_comb begin
    logic [DIV_W-1:0] hi_len;
    logic odd;
    hi_len = '0;
    odd = 1'b0;
    next_st = st;
    // ratio and run change only at the period boundary or while held, so enables give no runt pulses (see R9)
    if (hold_i || st.cnt == st.n_m1) begin
      next_st.cnt = '0;
      next_st.n_m1 = ratio_m1_i;
      next_st.run = run_req_i & ~hold_i;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
    // divide by programmed value plus one (see R2)
    odd = ~next_st.n_m1[0];
    // even ratio: high for exactly half the period (see R3)
    hi_len = odd ? (next_st.n_m1 >> 1) : ((next_st.n_m1 >> 1) + 1'b1);
    next_st.hi = next_st.run & (next_st.cnt < hi_len);
    // odd ratio: stretch high through the input high phase of one more cycle (see R5)
    next_st.ext = next_st.run & odd & (next_st.n_m1 != '0) & (next_st.cnt == (next_st.n_m1 >> 1));
  end

  // all channels leave reset from count zero, so equal ratios stay edge-aligned (see R16)
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ratio one bypasses the divider and passes the input duty cycle (see R4)
  // only the falling edge moves with the input duty cycle (see R6)
  assign wave_o = (st.n_m1 == '0) ? (clk_i & st.run) : (st.hi | (st.ext & clk_i));
  assign running_o = st.run;

endmodule

// ===== rtl/ocd_pkg.sv
// constants, field layouts and carrier types of the output clock distribution block
package ocd_pkg;

  localparam int NUM_CH = 4;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int RATIO_W = 30;

  // register map, one byte per address
  localparam logic [15:0] ADDR_SETTINGS = 16'h0400;
  localparam logic [15:0] ADDR_ENABLES = 16'h0401;
  localparam logic [15:0] ADDR_CFG_FIRST = 16'h0404;
  localparam logic [15:0] ADDR_CFG_LAST = 16'h0407;
  localparam logic [15:0] ADDR_RATIO_FIRST = 16'h0408;
  localparam logic [15:0] ADDR_RATIO_LAST = 16'h0417;
  localparam logic [15:0] ADDR_STATUS = 16'h0418;

  // distribution_settings fields
  localparam int SET_PD_LSB = 0;
  localparam int SET_HF_RX_BIT = 4;
  localparam int SET_EXT_RES_BIT = 5;

  // channel output config fields
  localparam int CFG_MODE_MSB = 2;
  localparam int CFG_POL_BIT = 3;
  localparam int CFG_PHASE_BIT = 4;
  localparam int CFG_DRIVE_BIT = 5;
  localparam int CFG_DIV_OE_BIT = 6;

  // status fields
  localparam int STAT_RUN_LSB = 0;
  localparam int STAT_SLEEP_BIT = 4;

  // mode field codes
  localparam logic [2:0] MODE_CMOS_BOTH = 3'h0;
  localparam logic [2:0] MODE_CMOS_POS = 3'h1;
  localparam logic [2:0] MODE_CMOS_NEG = 3'h2;
  localparam logic [2:0] MODE_TRISTATE = 3'h3;
  localparam logic [2:0] MODE_LVDS = 3'h4;
  localparam logic [2:0] MODE_LVPECL = 3'h5;

  // reset values
  localparam logic [7:0] RST_SETTINGS = 8'h00;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h40;
  localparam logic [31:0] RST_RATIO = 32'h0000_0000;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  typedef enum logic [1:0] {
    OCD_FAM_OFF,
    OCD_FAM_CMOS,
    OCD_FAM_LVDS,
    OCD_FAM_LVPECL
  } ocd_family_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ocd_bus_req_s;

  typedef struct packed {
    logic positive_output_pin;
    logic negative_output_pin;
    logic positive_oe_n;
    logic negative_oe_n;
    logic strong_drive;
    ocd_family_e family;
  } ocd_pins_s;

endpackage

// ===== rtl/ocd_top.sv
// four-channel output clock distribution: registers, channel dividers and output drivers
//
// Operation
// R1: four channels, each with its own divider and driver, fed by the distribution clock.
// R2: each divider holds a 30-bit value and divides by that value plus one.
// R3: even division ratios give an exact half-high, half-low output.
// R4: ratio one bypasses the divider and keeps the input duty cycle.
// R5: odd ratios above one give high fraction (N + 2X - 1)/(2N).
// R6: correction moves falling edges when noninverting, rising edges when inverted.
// R7: per-channel driver power-down; all four down puts the block in deep sleep.
// R8: in CMOS mode the divider output enable stalls output while divider stays aligned.
// R9: channel enables act through synchronizing logic; no runts, equal ratios move together.
// R10: each channel has its own mode register; its low three bits pick family and pins.
// R11: mode codes: CMOS both, CMOS pos, CMOS neg, tristate, LVDS, LVPECL, two unused.
// R12: polarity invert bit, default clear, swaps logic zero and one in every family.
// R13: CMOS phase invert drives the negative pin with the complement of the positive.
// R14: drive strength bit: weak at 0, strong at 1, ignored in LVPECL.
// R15: settings bit 4 routes the clock input through the high-frequency receiver.
// R16: after reset all dividers start together from one state, aligning equal ratios.
module ocd_top
  import ocd_pkg::*;
#(
  parameter int DIV_W = RATIO_W
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire ocd_bus_req_s bus_i,
  output logic [DATA_W-1:0] rdata_o,
  output ocd_pins_s [NUM_CH-1:0] chan_pins_o,
  output logic [NUM_CH-1:0] driver_power_down_o,
  output logic deep_sleep_o,
  output logic hf_receiver_sel_o,
  output logic ext_resistor_sel_o
);

  if (DIV_W < 2 || DIV_W > 32) begin : g_bad_width
    $error("ocd_top: DIV_W must lie between 2 and 32");
  end

  localparam int RATIO_BYTES = 4;

  typedef struct packed {
    logic [7:0] settings;
    logic [7:0] enables;
    logic [NUM_CH-1:0][7:0] cfg;
    logic [NUM_CH-1:0][31:0] ratio;
    logic [DATA_W-1:0] rdata;
  } ocd_top_state_s;

  ocd_top_state_s st;
  ocd_top_state_s next_st;

  logic [NUM_CH-1:0] wave;
  logic [NUM_CH-1:0] running;
  logic [NUM_CH-1:0] run_req;
  logic [NUM_CH-1:0] hold;
  logic sleep;

  // mask of ratio bits that the divider can hold
  function automatic logic [31:0] ratio_mask();
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < DIV_W; i++) begin
      m[i] = 1'b1;
    end
    return m;
  endfunction

  // true when the mode code selects one of the single-ended CMOS settings
  function automatic logic is_cmos(input logic [2:0] mode);
    return (mode == MODE_CMOS_BOTH) || (mode == MODE_CMOS_POS) || (mode == MODE_CMOS_NEG);
  endfunction

  function automatic logic in_range(input logic [ADDR_W-1:0] a, input logic [15:0] lo, input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [DATA_W-1:0] reg_read(input ocd_top_state_s s, input logic [ADDR_W-1:0] a,
                                                 input logic [NUM_CH-1:0] run_now, input logic slp);
    logic [DATA_W-1:0] d;
    logic [15:0] off;
    d = RDATA_UNMAPPED;
    off = 16'h0000;
    if (a == ADDR_SETTINGS) begin
      d = s.settings;
    end else if (a == ADDR_ENABLES) begin
      d = s.enables;
    end else if (in_range(a, ADDR_CFG_FIRST, ADDR_CFG_LAST)) begin
      off = a - ADDR_CFG_FIRST;
      d = s.cfg[off[1:0]];
    end else if (in_range(a, ADDR_RATIO_FIRST, ADDR_RATIO_LAST)) begin
      off = a - ADDR_RATIO_FIRST;
      d = s.ratio[off[3:2]][off[1:0]*8 +: 8];
    end else if (a == ADDR_STATUS) begin
      d = '0;
      d[STAT_RUN_LSB +: NUM_CH] = run_now;
      d[STAT_SLEEP_BIT] = slp;
    end
    return d;
  endfunction

  // register file and read path
  always_comb begin
    logic [15:0] off;
    logic [31:0] word;
    off = 16'h0000;
    word = '0;
    next_st = st;
    next_st.rdata = '0;
    if (bus_i.wr) begin
      if (bus_i.addr == ADDR_SETTINGS) begin
        next_st.settings = bus_i.wdata;
      end else if (bus_i.addr == ADDR_ENABLES) begin
        next_st.enables = bus_i.wdata;
      end else if (in_range(bus_i.addr, ADDR_CFG_FIRST, ADDR_CFG_LAST)) begin
        // one mode register per channel (see R10)
        off = bus_i.addr - ADDR_CFG_FIRST;
        next_st.cfg[off[1:0]] = bus_i.wdata;
      end else if (in_range(bus_i.addr, ADDR_RATIO_FIRST, ADDR_RATIO_LAST)) begin
        off = bus_i.addr - ADDR_RATIO_FIRST;
        word = st.ratio[off[3:2]];
        word[off[1:0]*8 +: 8] = bus_i.wdata;
        // only the divider's own width is stored (see R2)
        next_st.ratio[off[3:2]] = word & ratio_mask();
      end
    end
    if (bus_i.rd) begin
      next_st.rdata = reg_read(st, bus_i.addr, running, sleep);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st.settings <= RST_SETTINGS;
      st.enables <= RST_ENABLES;
      st.cfg <= {NUM_CH{RST_CFG}};
      st.ratio <= {NUM_CH{RST_RATIO}};
      st.rdata <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;

  // all four drivers down puts the whole block to sleep (see R7)
  assign driver_power_down_o = st.settings[SET_PD_LSB +: NUM_CH];
  assign sleep = &st.settings[SET_PD_LSB +: NUM_CH];
  assign deep_sleep_o = sleep;
  // receiver select for the distribution clock input (see R15)
  assign hf_receiver_sel_o = st.settings[SET_HF_RX_BIT];
  assign ext_resistor_sel_o = st.settings[SET_EXT_RES_BIT];

  // one divider per channel, all on the distribution clock (see R1)
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
    logic [2:0] mode;
    assign mode = st.cfg[c][CFG_MODE_MSB:0];
    // enable, and in CMOS the divider output enable, gate the run at the boundary (see R8)
    assign run_req[c] = st.enables[c] & (~is_cmos(mode) | st.cfg[c][CFG_DIV_OE_BIT]);

    // a disabled, stopped divider waits at count zero, so channels enabled together start together (see R9)
    assign hold[c] = sleep | (~st.enables[c] & ~running[c]);

    // deep sleep holds every divider at count zero so they restart together (see R16)
    ocd_chan_div #(
      .DIV_W(DIV_W)
    ) u_div (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .hold_i(hold[c]),
      .ratio_m1_i(st.ratio[c][DIV_W-1:0]),
      .run_req_i(run_req[c]),
      .wave_o(wave[c]),
      .running_o(running[c])
    );
  end

  // output driver per channel
  always_comb begin
    logic w;
    logic [2:0] mode;
    w = 1'b0;
    mode = 3'h0;
    for (int c = 0; c < NUM_CH; c++) begin
      mode = st.cfg[c][CFG_MODE_MSB:0];
      // polarity invert swaps zero and one for every family (see R12)
      w = wave[c] ^ st.cfg[c][CFG_POL_BIT];
      chan_pins_o[c].positive_output_pin = w;
      // phase invert only matters in CMOS; LVDS and LVPECL always drive complementary pins (see R13)
      chan_pins_o[c].negative_output_pin = w ^ st.cfg[c][CFG_PHASE_BIT];
      chan_pins_o[c].positive_oe_n = 1'b1;
      chan_pins_o[c].negative_oe_n = 1'b1;
      chan_pins_o[c].family = OCD_FAM_OFF;
      // mode decode (see R11)
      case (mode)
        MODE_CMOS_BOTH: begin
          chan_pins_o[c].family = OCD_FAM_CMOS;
          chan_pins_o[c].positive_oe_n = 1'b0;
          chan_pins_o[c].negative_oe_n = 1'b0;
        end
        MODE_CMOS_POS: begin
          chan_pins_o[c].family = OCD_FAM_CMOS;
          chan_pins_o[c].positive_oe_n = 1'b0;
        end
        MODE_CMOS_NEG: begin
          chan_pins_o[c].family = OCD_FAM_CMOS;
          chan_pins_o[c].negative_oe_n = 1'b0;
        end
        MODE_TRISTATE: begin
          chan_pins_o[c].family = OCD_FAM_CMOS;
        end
        MODE_LVDS: begin
          chan_pins_o[c].family = OCD_FAM_LVDS;
          chan_pins_o[c].negative_output_pin = ~w;
          chan_pins_o[c].positive_oe_n = 1'b0;
          chan_pins_o[c].negative_oe_n = 1'b0;
        end
        MODE_LVPECL: begin
          chan_pins_o[c].family = OCD_FAM_LVPECL;
          chan_pins_o[c].negative_output_pin = ~w;
          chan_pins_o[c].positive_oe_n = 1'b0;
          chan_pins_o[c].negative_oe_n = 1'b0;
        end
        default: begin
          chan_pins_o[c].family = OCD_FAM_OFF;
        end
      endcase
      // drive strength for every family except LVPECL (see R14)
      chan_pins_o[c].strong_drive = st.cfg[c][CFG_DRIVE_BIT] & (chan_pins_o[c].family != OCD_FAM_LVPECL);
      // a powered-down driver releases both pins (see R7)
      if (st.settings[SET_PD_LSB + c]) begin
        chan_pins_o[c].positive_oe_n = 1'b1;
        chan_pins_o[c].negative_oe_n = 1'b1;
        chan_pins_o[c].family = OCD_FAM_OFF;
        chan_pins_o[c].strong_drive = 1'b0;
      end
    end
  end

endmodule

// ===== tb/ocd_load_model.sv
// downstream clock receiver model: resolves the positive wire level
module ocd_load_model
  import ocd_pkg::*;
(
  input wire ocd_pins_s pins_i,
  output logic lvl_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // an undriven wire is pulled low by the termination
  assign lvl_o = pins_i.positive_oe_n ? 1'b0 : pins_i.positive_output_pin;
endmodule

// ===== tb/ocd_top_chk.sv
// concurrent checks on the ports of the clock distribution top
module ocd_top_chk
  import ocd_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire ocd_bus_req_s bus_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire ocd_pins_s [NUM_CH-1:0] chan_pins_o,
  input wire logic [NUM_CH-1:0] driver_power_down_o,
  input wire logic deep_sleep_o,
  input wire logic hf_receiver_sel_o,
  input wire logic ext_resistor_sel_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_set_wr;
    bus_i.wr && bus_i.addr == ADDR_SETTINGS;
  endsequence
  sequence s_set_rd;
    bus_i.rd && bus_i.addr == ADDR_SETTINGS;
  endsequence
  AST_PD_WR: assert property (s_set_wr |=> driver_power_down_o == $past(bus_i.wdata[3:0]))
    else $error("power-down bits not loaded");
  AST_SLEEP_WR: assert property (s_set_wr |=> deep_sleep_o == &$past(bus_i.wdata[3:0]))
    else $error("deep sleep wrong after write");
  AST_HOLD: assert property (!(bus_i.wr && bus_i.addr == ADDR_SETTINGS) |=> $stable(driver_power_down_o))
    else $error("power-down bits moved without write");
  AST_HF_WR: assert property (s_set_wr |=> hf_receiver_sel_o == $past(bus_i.wdata[SET_HF_RX_BIT]))
    else $error("receiver select not loaded");
  AST_SET_RD: assert property (s_set_rd |=> rdata_o[5:0] ==
    {$past(ext_resistor_sel_o), $past(hf_receiver_sel_o), $past(driver_power_down_o)})
    else $error("settings read back wrong");
  AST_RD_IDLE: assert property (!bus_i.rd |=> rdata_o == 8'h00)
    else $error("read data outside read slot");
  AST_PD_OE: assert property (driver_power_down_o[0] |->
    chan_pins_o[0].positive_oe_n && chan_pins_o[0].negative_oe_n)
    else $error("powered-down channel still driving");
  AST_PECL_DRV: assert property (chan_pins_o[2].family == OCD_FAM_LVPECL |-> !chan_pins_o[2].strong_drive)
    else $error("strong drive in lvpecl");
  AST_PECL_NEG: assert property (chan_pins_o[2].family == OCD_FAM_LVPECL && !driver_power_down_o[2] |->
    chan_pins_o[2].negative_output_pin == !chan_pins_o[2].positive_output_pin)
    else $error("lvpecl pins not complementary");
endmodule

bind ocd_top ocd_top_chk u_ocd_top_chk (.clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .chan_pins_o(chan_pins_o), .driver_power_down_o(driver_power_down_o), .deep_sleep_o(deep_sleep_o),
  .hf_receiver_sel_o(hf_receiver_sel_o), .ext_resistor_sel_o(ext_resistor_sel_o));

// ===== tb/test_ocd_top.sv
// self-checking bench for the output clock distribution block
module test_ocd_top
  import ocd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] OE_TAB = 16'hF0E4;
  localparam logic [15:0] FAM_TAB = 16'h0E55;
  localparam int IN_HI_HALVES = 1;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  ocd_bus_req_s bus_i = '0;
  logic [DATA_W-1:0] rdata_o;
  ocd_pins_s [NUM_CH-1:0] chan_pins_o;
  logic [NUM_CH-1:0] driver_power_down_o;
  logic [NUM_CH-1:0] lvl;
  logic deep_sleep_o;
  logic hf_receiver_sel_o;
  logic ext_resistor_sel_o;
  int n_fail = 0;
  int samples_checked = 0;
  int hi;
  logic [31:0] seed = 32'h0000A5DD;
  logic [7:0] d;
  logic [2:0] r;

  always #4 clk_i = ~clk_i;

  ocd_top u_ocd_top (.clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .chan_pins_o(chan_pins_o), .driver_power_down_o(driver_power_down_o), .deep_sleep_o(deep_sleep_o),
    .hf_receiver_sel_o(hf_receiver_sel_o), .ext_resistor_sel_o(ext_resistor_sel_o));

  for (genvar g = 0; g < NUM_CH; g++) begin : g_load
    ocd_load_model u_ocd_load_model (.pins_i(chan_pins_o[g]), .lvl_o(lvl[g]));
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // high half-cycles over one output period of ratio n
  function automatic int exp_hi(int n);
    return n - 1 + IN_HI_HALVES;
  endfunction

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(int a, int v);
    @(posedge clk_i);
    bus_i.addr <= 16'(a);
    bus_i.wdata <= 8'(v);
    bus_i.wr <= 1'b1;
    @(posedge clk_i);
    bus_i.wr <= 1'b0;
  endtask

  task automatic rc(int a, logic [7:0] e);
    @(posedge clk_i);
    bus_i.addr <= 16'(a);
    bus_i.rd <= 1'b1;
    @(posedge clk_i);
    bus_i.rd <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
    chk("rdata", d, e);
  endtask

  task automatic meas(int c, int n);
    hi = 0;
    repeat (n) begin
      @(posedge clk_i);
      #2 hi += lvl[c];
      #4 hi += lvl[c];
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    rc(ADDR_SETTINGS, 8'h00);
    rc(ADDR_ENABLES, 8'h00);
    for (int c = 0; c < NUM_CH; c++) rc(ADDR_CFG_FIRST + c, RST_CFG);
    wr(16'h0500, 8'hFF);
    rc(16'h0500, 8'h00);
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_CFG_FIRST + 2, 8'h60 + m);
      @(negedge clk_i);
      chk("oe", {chan_pins_o[2].positive_oe_n, chan_pins_o[2].negative_oe_n}, OE_TAB[2*m +: 2]);
      chk("fam", chan_pins_o[2].family, FAM_TAB[2*m +: 2]);
      chk("drv", chan_pins_o[2].strong_drive, m != 5);
    end
    wr(ADDR_RATIO_FIRST, 3);
    wr(ADDR_RATIO_FIRST + 12, 3);
    wr(ADDR_CFG_FIRST, 8'h50);
    wr(ADDR_CFG_FIRST + 3, 8'h48);
    wr(ADDR_CFG_FIRST + 2, 8'h40);
    wr(ADDR_CFG_FIRST + 1, 8'h64);
    wr(ADDR_ENABLES, 8'h0F);
    repeat (20) @(posedge clk_i);
    #2;
    repeat (16) begin
      chk("align", lvl[3], !lvl[0]);
      chk("phase", chan_pins_o[0].negative_output_pin, !chan_pins_o[0].positive_output_pin);
      chk("lvds", {chan_pins_o[1].family, chan_pins_o[1].strong_drive}, {OCD_FAM_LVDS, 1'b1});
      #4;
    end
    meas(0, 4);
    chk("hi0", hi, exp_hi(4));
    meas(2, 1);
    chk("hi2", hi, exp_hi(1));
    repeat (6) begin
      r = 3'(xs());
      wr(ADDR_RATIO_FIRST + 4, r);
      repeat (20) @(posedge clk_i);
      meas(1, r + 1);
      chk("hi1", hi, exp_hi(r + 1));
    end
    wr(ADDR_ENABLES, 8'h0E);
    repeat (10) @(posedge clk_i);
    meas(0, 4);
    chk("stop", hi, 0);
    wr(ADDR_CFG_FIRST + 1, 8'h00);
    repeat (20) @(posedge clk_i);
    meas(1, 8);
    chk("stall", hi, 0);
    rc(ADDR_STATUS, 8'h0C);
    wr(ADDR_SETTINGS, 8'h0F);
    rc(ADDR_STATUS, 8'h10);
    wr(ADDR_SETTINGS, 8'h31);
    @(negedge clk_i);
    chk("hf", hf_receiver_sel_o, 1);
    chk("pdoe", {chan_pins_o[0].positive_oe_n, chan_pins_o[0].negative_oe_n}, 2'b11);
    chk("sleep", deep_sleep_o, 0);
    chk("ext", ext_resistor_sel_o, 1);
    rc(ADDR_SETTINGS, 8'h31);
    test_done();
  end

  initial begin
    #100000;
    n_fail++;
    test_done();
  end
endmodule
